// ==== core/srs_status.sv ====
// Slave registration and communications stop status logic
// How it works
// - Completed bit 00 once all registered joined
// - Extra unregistered slaves do not block completion
// - Never completed with both tables empty
// - Completed holds until restart or power cycle
// - Missing bit 08 at monitoring timeout
// - Missing clears when culprit slaves join
// - Unregistered bit 09 when stranger joins
// - Unregistered holds until restart or power cycle
// - Stopped bit 10 on error in stop mode
// - Stopped holds until restart or power cycle
// - Error bit 15 high while 08-10 any set
// - Error bit clears when 08-10 clear
// - Stopped node number latched in bits 00-07
// - Per-node missing words at indexes 6, 7
// - Stopped slave type in bit 15
// - Monitoring time counted in 1 ms units
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module srs_status #(
	parameter int unsigned MS_CYCLES = srs_pkg::MS_CYCLES
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_B_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [15:0] WR_DATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [15:0] RD_DATA_O,
	input  wire logic [15:0] OUTPUT_JOINED_I,
	input  wire logic [15:0] INPUT_JOINED_I,
	input  wire logic        COMM_ERR_I,
	input  wire logic [3:0]  COMM_ERR_NODE_I,
	input  wire logic        COMM_ERR_INPUT_I,
	output logic             COMM_HALT_O,
	output logic             IRQ_O
);

	typedef enum logic [0:0] {
		SRS_MONITOR,
		SRS_EXPIRED
	} srs_phase_e;

	srs_phase_e       phase;
	logic [15:0]      output_node_table_bit;
	logic [15:0]      input_node_table_bit;
	logic [15:0]      mon_time;
	logic             stop_mode;
	logic             restart;
	logic [16:0]      ms_cnt;
	logic             ms_tick;
	logic [15:0]      elapsed;
	logic [15:0]      mon_limit;
	logic             reg_done;
	logic [15:0]      miss_output;
	logic [15:0]      miss_input;
	logic             unreg;
	logic             stopped;
	logic [7:0]       stop_node;
	logic             stop_type;
	logic             tables_empty;
	logic             all_joined;
	logic             stranger;
	logic             stop_event;
	logic             missing;
	logic [15:0]      flags_word;
	logic [15:0]      info_word;
	logic [srs_pkg::IRQ_W-1:0] irq_status;
	logic [srs_pkg::IRQ_W-1:0] irq_mask;
	logic [srs_pkg::IRQ_W-1:0] irq_event;
	logic [srs_pkg::IRQ_W-1:0] next_irq_status;
	logic             wr_flags_prev;
	logic             missing_prev;

	// Every marked node of a table is present on the network
	function automatic logic table_met(input logic [15:0] table_bits,
		input logic [15:0] joined);
		table_met = (table_bits & joined) == table_bits;
	endfunction

	function automatic logic is_wr(input logic [7:0] addr, input logic wr,
		input logic [7:0] ofs);
		is_wr = wr && (addr == ofs);
	endfunction

	// Host written tables and configuration; no read-only word is writable
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			output_node_table_bit <= srs_pkg::RST_TABLE;
			input_node_table_bit  <= srs_pkg::RST_TABLE;
			mon_time              <= srs_pkg::RST_MON_TIME;
			stop_mode             <= srs_pkg::RST_CONTROL[srs_pkg::BIT_STOP_MODE];
		end else begin
			if (is_wr(ADDR_I, WR_I, srs_pkg::OFS_OUTPUT_TABLE)) begin
				output_node_table_bit <= WR_DATA_I;
			end
			if (is_wr(ADDR_I, WR_I, srs_pkg::OFS_INPUT_TABLE)) begin
				input_node_table_bit <= WR_DATA_I;
			end
			if (is_wr(ADDR_I, WR_I, srs_pkg::OFS_MON_TIME)) begin
				mon_time <= WR_DATA_I;
			end
			if (is_wr(ADDR_I, WR_I, srs_pkg::OFS_CONTROL)) begin
				stop_mode <= WR_DATA_I[srs_pkg::BIT_STOP_MODE];
			end
		end
	end

	// Unit restart is a write-one pulse; it clears status except the interrupt status, not settings
	always_comb begin
		restart = is_wr(ADDR_I, WR_I, srs_pkg::OFS_CONTROL) &&
			WR_DATA_I[srs_pkg::BIT_RESTART];
	end

	always_comb begin
		tables_empty = (output_node_table_bit | input_node_table_bit) == 16'h0000;
		all_joined = table_met(output_node_table_bit, OUTPUT_JOINED_I) &&
			table_met(input_node_table_bit, INPUT_JOINED_I);
		stranger = ((OUTPUT_JOINED_I & ~output_node_table_bit) |
			(INPUT_JOINED_I & ~input_node_table_bit)) != 16'h0000;
		mon_limit = (mon_time == 16'h0000) ? srs_pkg::MON_TIME_DEFAULT :
			mon_time;
		stop_event = stop_mode && COMM_ERR_I && !stopped;
		missing = (miss_output | miss_input) != 16'h0000;
	end

	// One millisecond tick
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I || restart) begin
			ms_cnt  <= 17'h00000;
			ms_tick <= 1'b0;
		end else if (ms_cnt == 17'(MS_CYCLES - 1)) begin
			ms_cnt  <= 17'h00000;
			ms_tick <= 1'b1;
		end else begin
			ms_cnt  <= ms_cnt + 17'h00001;
			ms_tick <= 1'b0;
		end
	end

	// Participation monitoring window from reset or restart
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I || restart) begin
			phase   <= SRS_MONITOR;
			elapsed <= 16'h0000;
		end else begin
			case (phase)
				SRS_MONITOR: begin
					if (ms_tick) begin
						elapsed <= elapsed + 16'h0001;
						if (elapsed + 16'h0001 >= mon_limit) begin
							phase <= SRS_EXPIRED;
						end
					end
				end
				SRS_EXPIRED: begin
					phase <= SRS_EXPIRED;
				end
				default: begin
					phase <= SRS_MONITOR;
				end
			endcase
		end
	end

	// Completion ignores strangers; never completes while both tables are empty
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I || restart) begin
			reg_done <= 1'b0;
		end else if (all_joined && !tables_empty) begin
			reg_done <= 1'b1;
		end
	end

	// Per-node missing words, captured at timeout then cleared per node
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I || restart) begin
			miss_output <= 16'h0000;
			miss_input  <= 16'h0000;
		end else if (phase == SRS_MONITOR && ms_tick &&
			elapsed + 16'h0001 >= mon_limit) begin
			miss_output <= output_node_table_bit & ~OUTPUT_JOINED_I;
			miss_input  <= input_node_table_bit & ~INPUT_JOINED_I;
		end else begin
			miss_output <= miss_output & ~OUTPUT_JOINED_I;
			miss_input  <= miss_input & ~INPUT_JOINED_I;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I || restart) begin
			unreg <= 1'b0;
		end else if (stranger) begin
			unreg <= 1'b1;
		end
	end

	// First error in stop mode wins; later errors do not overwrite it
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I || restart) begin
			stopped   <= 1'b0;
			stop_node <= 8'h00;
			stop_type <= 1'b0;
		end else if (stop_event) begin
			stopped   <= 1'b1;
			stop_node <= {4'h0, COMM_ERR_NODE_I};
			stop_type <= COMM_ERR_INPUT_I;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			COMM_HALT_O <= 1'b0;
		end else begin
			COMM_HALT_O <= stop_event || (stopped && !restart);
		end
	end

	// Status words; unlisted bits stay zero
	always_comb begin
		flags_word = 16'h0000;
		flags_word[srs_pkg::BIT_REG_DONE] = reg_done;
		flags_word[srs_pkg::BIT_MISSING]  = missing;
		flags_word[srs_pkg::BIT_UNREG]    = unreg;
		flags_word[srs_pkg::BIT_STOPPED]  = stopped;
		flags_word[srs_pkg::BIT_ERROR]    = missing || unreg || stopped;
		info_word = 16'h0000;
		info_word[srs_pkg::STOP_NODE_LSB +: srs_pkg::STOP_NODE_W] = stop_node;
		info_word[srs_pkg::BIT_STOP_TYPE] = stop_type;
	end

	// Read data valid the cycle after the read strobe only
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I || !RD_I) begin
			RD_DATA_O <= 16'h0000;
		end else begin
			case (ADDR_I)
				srs_pkg::OFS_OUTPUT_TABLE: RD_DATA_O <= output_node_table_bit;
				srs_pkg::OFS_INPUT_TABLE:  RD_DATA_O <= input_node_table_bit;
				srs_pkg::OFS_MON_TIME:     RD_DATA_O <= mon_time;
				srs_pkg::OFS_FLAGS:        RD_DATA_O <= flags_word;
				srs_pkg::OFS_STOP_INFO:    RD_DATA_O <= info_word;
				srs_pkg::OFS_MISS_OUTPUT:  RD_DATA_O <= miss_output;
				srs_pkg::OFS_MISS_INPUT:   RD_DATA_O <= miss_input;
				srs_pkg::OFS_CONTROL: begin
					RD_DATA_O <= {15'h0000, stop_mode};
				end
				srs_pkg::OFS_IRQ_STATUS: begin
					RD_DATA_O <= {12'h000, irq_status};
				end
				srs_pkg::OFS_IRQ_MASK: begin
					RD_DATA_O <= {12'h000, irq_mask};
				end
				default: RD_DATA_O <= 16'h0000;
			endcase
		end
	end

	// Rising edges of the flags become interrupt events
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			wr_flags_prev <= 1'b0;
			missing_prev  <= 1'b0;
		end else begin
			wr_flags_prev <= reg_done;
			missing_prev  <= missing;
		end
	end

	always_comb begin
		irq_event = '0;
		irq_event[srs_pkg::IRQ_DONE]    = reg_done && !wr_flags_prev;
		irq_event[srs_pkg::IRQ_MISSING] = missing && !missing_prev;
		irq_event[srs_pkg::IRQ_UNREG]   = stranger && !unreg;
		irq_event[srs_pkg::IRQ_STOPPED] = stop_event;
		next_irq_status = irq_status;
		if (is_wr(ADDR_I, WR_I, srs_pkg::OFS_IRQ_STATUS)) begin
			next_irq_status = irq_status & ~WR_DATA_I[srs_pkg::IRQ_W-1:0];
		end
		// Set beats a same-cycle clear so no event is lost
		next_irq_status = next_irq_status | irq_event;
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			irq_status <= '0;
			irq_mask   <= srs_pkg::RST_MASK;
			IRQ_O      <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (is_wr(ADDR_I, WR_I, srs_pkg::OFS_IRQ_MASK)) begin
				irq_mask <= WR_DATA_I[srs_pkg::IRQ_W-1:0];
			end
			IRQ_O <= (irq_status & irq_mask) != '0;
		end
	end

endmodule

// ==== core/srs_pkg.sv ====
// Constants for the slave registration status block
package srs_pkg;
	// Register indexes on the plain register port
	localparam logic [7:0] OFS_OUTPUT_TABLE = 8'h00;
	localparam logic [7:0] OFS_INPUT_TABLE  = 8'h01;
	localparam logic [7:0] OFS_MON_TIME     = 8'h02;
	localparam logic [7:0] OFS_FLAGS        = 8'h04;
	localparam logic [7:0] OFS_STOP_INFO    = 8'h05;
	localparam logic [7:0] OFS_MISS_OUTPUT  = 8'h06;
	localparam logic [7:0] OFS_MISS_INPUT   = 8'h07;
	localparam logic [7:0] OFS_CONTROL      = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS   = 8'h11;
	localparam logic [7:0] OFS_IRQ_MASK     = 8'h12;

	// Flag word bit positions
	localparam int BIT_REG_DONE  = 0;
	localparam int BIT_MISSING   = 8;
	localparam int BIT_UNREG     = 9;
	localparam int BIT_STOPPED   = 10;
	localparam int BIT_ERROR     = 15;

	// Stop info word fields
	localparam int STOP_NODE_LSB = 0;
	localparam int STOP_NODE_W   = 8;
	localparam int BIT_STOP_TYPE = 15;

	// Control word bits
	localparam int BIT_STOP_MODE = 0;
	localparam int BIT_RESTART   = 1;

	// Interrupt status and mask bits
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_MISSING   = 1;
	localparam int IRQ_UNREG     = 2;
	localparam int IRQ_STOPPED   = 3;
	localparam int IRQ_W         = 4;

	// Reset values
	localparam logic [15:0] RST_TABLE    = 16'h0000;
	localparam logic [15:0] RST_MON_TIME = 16'h0000;
	localparam logic [15:0] RST_CONTROL  = 16'h0000;
	localparam logic [3:0]  RST_MASK     = 4'h0;

	// Monitoring time: zero selects the default
	localparam logic [15:0] MON_TIME_DEFAULT = 16'h07D0;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
endpackage

// ==== sim/srs_status_props.sv ====
// Port checker for the registration status block
`timescale 1ns/100ps
module srs_status_props (
	input wire logic        CLK_SYS_I,
	input wire logic        RST_B_I,
	input wire logic [7:0]  ADDR_I,
	input wire logic [15:0] WR_DATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [15:0] RD_DATA_O,
	input wire logic        COMM_ERR_I,
	input wire logic        COMM_HALT_O,
	input wire logic        IRQ_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);
	logic restart;
	assign restart = WR_I && ADDR_I == srs_pkg::OFS_CONTROL && WR_DATA_I[1];
	sequence flags_rd;
		RD_I && ADDR_I == srs_pkg::OFS_FLAGS;
	endsequence
	sequence info_rd;
		RD_I && ADDR_I == srs_pkg::OFS_STOP_INFO;
	endsequence
	rd_idle_a: assert property (!RD_I |=> RD_DATA_O == 16'h0000)
		else $error("read data not idle");
	halt_hold_a: assert property (COMM_HALT_O && !restart |=> COMM_HALT_O)
		else $error("halt dropped");
	halt_cause_a: assert property ($rose(COMM_HALT_O) |-> $past(COMM_ERR_I))
		else $error("halt without error");
	error_sum_a: assert property (flags_rd |=> RD_DATA_O[15] == |RD_DATA_O[10:8])
		else $error("summary flag wrong");
	flags_rsv_a: assert property (flags_rd |=> RD_DATA_O[14:11] == 4'h0 && RD_DATA_O[7:1] == 7'h00)
		else $error("flag reserved bits set");
	halt_flag_a: assert property (COMM_HALT_O ##0 flags_rd |=> RD_DATA_O[10])
		else $error("stopped flag low");
	info_rsv_a: assert property (info_rd |=> RD_DATA_O[14:4] == 11'h000)
		else $error("stop info out of range");
	unmapped_a: assert property (RD_I && ADDR_I == 8'h03 |=> RD_DATA_O == 16'h0000)
		else $error("unmapped read not zero");
endmodule
bind srs_status srs_status_props u_props (.CLK_SYS_I(CLK_SYS_I),
	.RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I),
	.RD_I(RD_I), .RD_DATA_O(RD_DATA_O), .COMM_ERR_I(COMM_ERR_I),
	.COMM_HALT_O(COMM_HALT_O), .IRQ_O(IRQ_O));

// ==== sim/srs_net_model.sv ====
// Network of remote output and input slaves
`timescale 1ns/100ps
module srs_net_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] out_want_i,
	input  wire logic [15:0] in_want_i,
	input  wire logic        slow_i,
	input  wire logic        err_req_i,
	input  wire logic [4:0]  err_who_i,
	output logic      [15:0] out_joined_o,
	output logic      [15:0] in_joined_o,
	output logic             err_o,
	output logic      [3:0]  err_node_o,
	output logic             err_input_o
);
	logic [3:0] wait_cnt;
	// Slow slaves need 13 cycles to join or drop
	always_ff @(posedge clk_i) begin
		if ({out_want_i, in_want_i} == {out_joined_o, in_joined_o}) begin
			wait_cnt <= slow_i ? 4'hC : 4'h0;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else begin
			out_joined_o <= out_want_i;
			in_joined_o <= in_want_i;
		end
	end
	// Node lines toggle outside a report so stale values never match
	always_ff @(posedge clk_i) begin
		err_o <= err_req_i;
		if (err_req_i) begin
			{err_input_o, err_node_o} <= err_who_i;
		end else begin
			{err_input_o, err_node_o} <= ~{err_input_o, err_node_o};
		end
	end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the registration status block
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("BAD %0t got %h want %h", $time, a, e); end end
module tb;
	logic clk, rst_b, wr, rd, slow, err_req, err, err_in, irq, halt;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, out_want, in_want, out_j, in_j, ot, it, m;
	logic [4:0] who;
	logic [3:0] err_node;
	logic [31:0] seed = 32'h48;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	srs_status #(.MS_CYCLES(10)) dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b),
		.ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RD_DATA_O(rdata), .OUTPUT_JOINED_I(out_j), .INPUT_JOINED_I(in_j),
		.COMM_ERR_I(err), .COMM_ERR_NODE_I(err_node),
		.COMM_ERR_INPUT_I(err_in), .COMM_HALT_O(halt), .IRQ_O(irq));
	srs_net_model net_u (.clk_i(clk), .out_want_i(out_want),
		.in_want_i(in_want), .slow_i(slow), .err_req_i(err_req),
		.err_who_i(who), .out_joined_o(out_j), .in_joined_o(in_j),
		.err_o(err), .err_node_o(err_node), .err_input_o(err_in));
	always #4 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] fl(logic d, logic ms, logic u, logic s);
		return {ms | u | s, 4'h0, s, u, ms, 7'h00, d};
	endfunction
	task automatic end_of_test();
		$display("err_count %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(logic [7:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(logic [7:0] a, logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		{clk, rst_b, wr, rd, slow, err_req, addr, wdata, who} = '0;
		{out_want, in_want} = '0;
		wt(3);
		rst_b <= 1'b1;
		rd_chk(srs_pkg::OFS_FLAGS, 16'h0000);
		ot = rnd();
		ot = (ot & 16'h7FFF) | 16'h0001;
		it = rnd();
		m = ot & -ot;
		wr_reg(srs_pkg::OFS_OUTPUT_TABLE, ot);
		wr_reg(srs_pkg::OFS_INPUT_TABLE, it);
		wr_reg(srs_pkg::OFS_MON_TIME, 16'h0003);
		rd_chk(srs_pkg::OFS_OUTPUT_TABLE, ot);
		wr_reg(srs_pkg::OFS_IRQ_MASK, 16'h000F);
		wr_reg(srs_pkg::OFS_CONTROL, 16'h0003);
		out_want <= ot | 16'h8000;
		in_want <= it;
		wt(15);
		rd_chk(srs_pkg::OFS_FLAGS, fl(1, 0, 1, 0));
		`CHK(irq, 1'b1)
		wr_reg(srs_pkg::OFS_IRQ_STATUS, 16'h000F);
		wt(2);
		`CHK(irq, 1'b0)
		out_want <= ot & ~m;
		slow <= 1'b1;
		wt(20);
		rd_chk(srs_pkg::OFS_FLAGS, fl(1, 1, 1, 0));
		wr_reg(srs_pkg::OFS_CONTROL, 16'h0003);
		wt(45);
		rd_chk(srs_pkg::OFS_FLAGS, fl(0, 1, 0, 0));
		rd_chk(srs_pkg::OFS_MISS_OUTPUT, m);
		`CHK(irq, 1'b1)
		out_want <= ot;
		wt(20);
		rd_chk(srs_pkg::OFS_FLAGS, fl(1, 0, 0, 0));
		wr_reg(srs_pkg::OFS_CONTROL, 16'h0000);
		who <= 5'h13;
		err_req <= 1'b1;
		wt(1);
		err_req <= 1'b0;
		wt(3);
		`CHK(halt, 1'b0)
		wr_reg(srs_pkg::OFS_CONTROL, 16'h0001);
		for (int i = 0; i < 2; i++) begin
			who <= (i == 0) ? rnd() : 5'h0A;
			err_req <= 1'b1;
			wt(1);
			err_req <= 1'b0;
			if (i == 0) begin
				m = {who[4], 11'h000, who[3:0]};
			end
			wt(3);
			`CHK(halt, 1'b1)
			rd_chk(srs_pkg::OFS_STOP_INFO, m);
		end
		rd_chk(srs_pkg::OFS_FLAGS, fl(1, 0, 0, 1));
		wr_reg(srs_pkg::OFS_FLAGS, 16'hFFFF);
		rd_chk(srs_pkg::OFS_FLAGS, fl(1, 0, 0, 1));
		rd_chk(8'h03, 16'h0000);
		wr_reg(srs_pkg::OFS_OUTPUT_TABLE, 16'h0000);
		wr_reg(srs_pkg::OFS_INPUT_TABLE, 16'h0000);
		wr_reg(srs_pkg::OFS_CONTROL, 16'h0003);
		wt(3);
		`CHK(halt, 1'b0)
		wt(45);
		rd_chk(srs_pkg::OFS_FLAGS, fl(0, 0, 1, 0));
		end_of_test();
	end
endmodule
